// *** rtl/pwd_consts.svh ***
// Offsets, field positions, reset values and timing for the parameter word decoder
`ifndef PWD_CONSTS_SVH
`define PWD_CONSTS_SVH

`define PWD_ROM_PRESENT_BIT 11
`define PWD_ROM_CAP_HI      13
`define PWD_ROM_CAP_LO      12
`define PWD_ROM_CAP_RSV_BIT 13
`define PWD_WAKE_PULSE_BIT  0
`define PWD_LOW_MEG_BIT     1
`define PWD_WIN_OFF_BIT     2
`define PWD_MIN_GNT_HI      9
`define PWD_MIN_GNT_LO      6
`define PWD_MAX_LAT_HI      15
`define PWD_MAX_LAT_LO      10
`define PWD_MG_REG_HI       4
`define PWD_MG_REG_LO       1
`define PWD_ML_REG_HI       5
`define PWD_ML_REG_LO       0
`define PWD_PARAM_RESET     16'h1540
`define PWD_ROM_RESET       16'h0000
`define PWD_BAR_BASE_LSB    7
`define PWD_BAR_BASE_W      25
`define PWD_BAR_MAP_POS     1

`define PWD_OFS_ROM         8'h00
`define PWD_OFS_PARAM       8'h04
`define PWD_OFS_BAR         8'h08
`define PWD_OFS_GRANT       8'h0C
`define PWD_OFS_STATUS      8'h10
`define PWD_OFS_CONTROL     8'h14
`define PWD_ST_PARAM_LD     0
`define PWD_ST_ROM_LD       1
`define PWD_ST_PME_LEVEL    2
`define PWD_ST_PULSE_BUSY   3
`define PWD_ST_PME_PIN      4
`define PWD_ST_CAP_RSV      5
`define PWD_CTL_WAKE_EN     0

`define PWD_PME_PULSE_NS    100000
`define PWD_CLK_PERIOD_NS   8

`endif

// *** rtl/pwd_pkg.sv ***
// Types shared by the parameter word decoder modules
`include "pwd_consts.svh"

package pwd_pkg;

	typedef enum logic [1:0] {
		PWD_T_IDLE = 2'b01,
		PWD_T_RUN  = 2'b10
	} pwd_timer_state_type;

	typedef struct packed {
		logic meta;
		logic stable;
	} pwd_sync_type;

	typedef struct packed {
		pwd_timer_state_type state;
		logic [31:0]         count;
	} pwd_timer_type;

	typedef struct packed {
		logic [15:0]                rom_word;
		logic [15:0]                param_word;
		logic                       rom_loaded;
		logic                       param_loaded;
		logic [`PWD_BAR_BASE_W-1:0] bar_base;
		logic                       wake_enable;
		logic                       wake_prev;
		logic                       pme_level;
		logic                       pulse_start;
		logic                       pme_oe;
		logic                       pme_o;
		logic                       waitreq;
		logic [31:0]                readdata;
		logic [31:0]                out_bar;
		logic [7:0]                 out_min_grant;
		logic [7:0]                 out_max_latency;
		logic                       out_window_off;
		logic                       out_rom_installed;
		logic [1:0]                 out_rom_capacity;
		logic                       out_rom_reserved;
	} pwd_core_type;

endpackage : pwd_pkg

// *** rtl/pwd_pulse_if.sv ***
// Start and busy pair between the decoder core and the wake pulse timer
interface pwd_pulse_if;
	logic start;
	logic busy;
	modport ctrl  (output start, input busy);
	modport timer (input start, output busy);
endinterface : pwd_pulse_if

// *** rtl/pwd_sync2.sv ***
// Two flip-flop synchroniser for one pin level
module pwd_sync2 (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      sync_out
);
	pwd_pkg::pwd_sync_type s_q;
	pwd_pkg::pwd_sync_type s_d;

	always_comb begin
		s_d.meta   = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule : pwd_sync2

// *** rtl/pwd_pulse_timer.sv ***
// Retriggerable one-shot that times the wake pulse
module pwd_pulse_timer #(
	parameter int unsigned PULSE_CYCLES = 12500
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	pwd_pulse_if.timer pulse
);
	pwd_pkg::pwd_timer_type s_q;
	pwd_pkg::pwd_timer_type s_d;

	always_comb begin
		s_d = s_q;
		case (s_q.state)
			pwd_pkg::PWD_T_IDLE: begin
				if (pulse.start) begin
					s_d.state = pwd_pkg::PWD_T_RUN;
					s_d.count = 32'(PULSE_CYCLES - 1);
				end
			end
			pwd_pkg::PWD_T_RUN: begin
				// A fresh wake event restarts the full width
				if (pulse.start) begin
					s_d.count = 32'(PULSE_CYCLES - 1);
				end else if (s_q.count == 32'h0) begin
					s_d.state = pwd_pkg::PWD_T_IDLE;
				end else begin
					s_d.count = s_q.count - 32'h1;
				end
			end
			default: begin
				s_d.state = pwd_pkg::PWD_T_IDLE;
				s_d.count = 32'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q.state <= pwd_pkg::PWD_T_IDLE;
			s_q.count <= 32'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse.busy = (s_q.state == pwd_pkg::PWD_T_RUN);
endmodule : pwd_pulse_timer

// *** rtl/pwd_decoder_top.sv ***
// Parameter word decoder: EEPROM word capture, field decode, wake pulse and Avalon-MM registers
`include "pwd_consts.svh"

module pwd_decoder_top #(
	parameter int unsigned PME_PULSE_CYCLES = `PWD_PME_PULSE_NS / `PWD_CLK_PERIOD_NS,
	parameter logic [7:0]  ROM_WORD_ADDR    = 8'h08,
	parameter logic [7:0]  PARAM_WORD_ADDR  = 8'h07
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ee_word_valid,
	input  wire logic [7:0]  ee_word_addr,
	input  wire logic [15:0] ee_word_data,
	input  wire logic        wake_event_pin,
	input  wire logic        pme_i,
	output logic             pme_o,
	output logic             pme_oe,
	output logic      [31:0] memory_window_base,
	output logic      [7:0]  minimum_grant_register,
	output logic      [7:0]  maximum_latency_register,
	output logic             memory_window_off,
	output logic             bios_rom_installed,
	output logic      [1:0]  bios_rom_capacity,
	output logic             bios_rom_capacity_reserved,
	output logic             param_loaded
);

	// ************************************************************
	// State and helpers
	// ************************************************************

	pwd_pkg::pwd_core_type s_q;
	pwd_pkg::pwd_core_type s_d;

	logic wake_sync;
	logic pme_pin_sync;

	pwd_pulse_if pulse_if ();

	// ************************************************************
	// Pin synchronisers and pulse timer
	// ************************************************************

	// Wake events arrive from outside the clock domain
	pwd_sync2 u_wake_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in (wake_event_pin),
		.sync_out (wake_sync)
	);

	// Wired-OR wake line level, for status only
	pwd_sync2 u_pme_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in (pme_i),
		.sync_out (pme_pin_sync)
	);

	pwd_pulse_timer #(
		.PULSE_CYCLES (PME_PULSE_CYCLES)
	) u_pulse (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.pulse   (pulse_if.timer)
	);

	assign pulse_if.start = s_q.pulse_start;

	// ************************************************************
	// Field views of the parameter word
	// ************************************************************

	function automatic logic [7:0] pwd_min_grant_view(input logic [15:0] word);
		logic [7:0] r;
		r = 8'h00;
		r[`PWD_MG_REG_HI:`PWD_MG_REG_LO] = word[`PWD_MIN_GNT_HI:`PWD_MIN_GNT_LO];
		return r;
	endfunction : pwd_min_grant_view

	function automatic logic [7:0] pwd_max_latency_view(input logic [15:0] word);
		logic [7:0] r;
		r = 8'h00;
		r[`PWD_ML_REG_HI:`PWD_ML_REG_LO] = word[`PWD_MAX_LAT_HI:`PWD_MAX_LAT_LO];
		return r;
	endfunction : pwd_max_latency_view

	// Window base register as the host sees it
	function automatic logic [31:0] pwd_bar_view(
		input logic [`PWD_BAR_BASE_W-1:0] base,
		input logic [15:0]                word
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (!word[`PWD_WIN_OFF_BIT]) begin
			r[31:`PWD_BAR_BASE_LSB] = base;
		end
		r[`PWD_BAR_MAP_POS] = word[`PWD_LOW_MEG_BIT];
		return r;
	endfunction : pwd_bar_view

	// ************************************************************
	// Next-state logic
	// ************************************************************

	always_comb begin
		logic [31:0] rd;
		logic [31:0] bar_old;
		logic [31:0] merged;
		logic        wake_rise;
		logic        req_new;
		logic        wr_commit;
		rd        = 32'h0000_0000;
		bar_old   = {s_q.bar_base, {`PWD_BAR_BASE_LSB{1'b0}}};
		merged    = 32'h0000_0000;
		wake_rise = wake_sync && !s_q.wake_prev;
		req_new   = (avs_read || avs_write) && s_q.waitreq;
		wr_commit = avs_write && !s_q.waitreq;

		s_d             = s_q;
		s_d.pulse_start = 1'b0;
		s_d.wake_prev   = wake_sync;
		s_d.pme_o       = 1'b0;

		// Read mux, sampled when the request is first seen
		case (avs_address)
			`PWD_OFS_ROM: begin
				rd[15:0] = s_q.rom_word;
			end
			`PWD_OFS_PARAM: begin
				rd[15:0] = s_q.param_word;
			end
			`PWD_OFS_BAR: begin
				rd = pwd_bar_view(s_q.bar_base, s_q.param_word);
			end
			`PWD_OFS_GRANT: begin
				rd[7:0]  = pwd_min_grant_view(s_q.param_word);
				rd[15:8] = pwd_max_latency_view(s_q.param_word);
			end
			`PWD_OFS_STATUS: begin
				rd[`PWD_ST_PARAM_LD]   = s_q.param_loaded;
				rd[`PWD_ST_ROM_LD]     = s_q.rom_loaded;
				rd[`PWD_ST_PME_LEVEL]  = s_q.pme_level;
				rd[`PWD_ST_PULSE_BUSY] = pulse_if.busy;
				rd[`PWD_ST_PME_PIN]    = pme_pin_sync;
				rd[`PWD_ST_CAP_RSV]    = s_q.out_rom_reserved;
			end
			`PWD_OFS_CONTROL: begin
				rd[`PWD_CTL_WAKE_EN] = s_q.wake_enable;
			end
			default: begin
				rd = 32'h0000_0000;
			end
		endcase

		// One wait cycle, then a single answer cycle
		if (req_new) begin
			s_d.waitreq  = 1'b0;
			s_d.readdata = avs_read ? rd : 32'h0000_0000;
		end else begin
			s_d.waitreq = 1'b1;
		end

		// Writes land on the edge where waitrequest is seen low
		if (wr_commit) begin
			case (avs_address)
				`PWD_OFS_BAR: begin
					for (int b = 0; b < 4; b++) begin
						merged[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8] : bar_old[8*b +: 8];
					end
					s_d.bar_base = merged[31:`PWD_BAR_BASE_LSB];
				end
				`PWD_OFS_STATUS: begin
					if (avs_byteenable[0] && avs_writedata[`PWD_ST_PME_LEVEL]) begin
						s_d.pme_level = 1'b0;
					end
				end
				`PWD_OFS_CONTROL: begin
					if (avs_byteenable[0]) begin
						s_d.wake_enable = avs_writedata[`PWD_CTL_WAKE_EN];
					end
				end
				default: begin
					s_d.wake_enable = s_q.wake_enable;
				end
			endcase
		end

		// EEPROM words come from the loader on this clock
		if (ee_word_valid) begin
			if (ee_word_addr == ROM_WORD_ADDR) begin
				s_d.rom_word   = ee_word_data;
				s_d.rom_loaded = 1'b1;
			end
			if (ee_word_addr == PARAM_WORD_ADDR) begin
				s_d.param_word   = ee_word_data;
				s_d.param_loaded = 1'b1;
			end
		end

		if (s_d.param_word[`PWD_WIN_OFF_BIT]) begin
			s_d.bar_base = '0;
		end

		// Pulse or latched level per wake event
		// Placed after the status clear so a coincident event survives
		if (wake_rise && s_q.wake_enable) begin
			if (s_q.param_word[`PWD_WAKE_PULSE_BIT]) begin
				s_d.pulse_start = 1'b1;
			end else begin
				s_d.pme_level = 1'b1;
			end
		end

		// Open-drain: enable pulls the line low
		s_d.pme_oe = s_q.pme_level || pulse_if.busy;

		// Only the named fields are decoded
		s_d.out_bar         = pwd_bar_view(s_d.bar_base, s_d.param_word);
		s_d.out_min_grant   = pwd_min_grant_view(s_d.param_word);
		s_d.out_max_latency = pwd_max_latency_view(s_d.param_word);
		s_d.out_window_off  = s_d.param_word[`PWD_WIN_OFF_BIT];

		s_d.out_rom_installed = s_d.rom_word[`PWD_ROM_PRESENT_BIT];
		s_d.out_rom_capacity = s_d.rom_word[`PWD_ROM_CAP_HI:`PWD_ROM_CAP_LO];
		s_d.out_rom_reserved = s_d.rom_word[`PWD_ROM_PRESENT_BIT] && s_d.rom_word[`PWD_ROM_CAP_RSV_BIT];
	end

	// ************************************************************
	// State register
	// ************************************************************

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q                 <= '0;
			s_q.rom_word        <= `PWD_ROM_RESET;
			s_q.param_word      <= `PWD_PARAM_RESET;
			s_q.waitreq         <= 1'b1;
			s_q.out_bar         <= pwd_bar_view('0, `PWD_PARAM_RESET);
			s_q.out_min_grant   <= pwd_min_grant_view(`PWD_PARAM_RESET);
			s_q.out_max_latency <= pwd_max_latency_view(`PWD_PARAM_RESET);
			s_q.out_window_off  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs, each straight from the state register
	// ************************************************************

	assign avs_readdata               = s_q.readdata;
	assign avs_waitrequest            = s_q.waitreq;
	assign pme_o                      = s_q.pme_o;
	assign pme_oe                     = s_q.pme_oe;
	assign memory_window_base         = s_q.out_bar;
	assign minimum_grant_register     = s_q.out_min_grant;
	assign maximum_latency_register   = s_q.out_max_latency;
	assign memory_window_off          = s_q.out_window_off;
	assign bios_rom_installed         = s_q.out_rom_installed;
	assign bios_rom_capacity          = s_q.out_rom_capacity;
	assign bios_rom_capacity_reserved = s_q.out_rom_reserved;
	assign param_loaded               = s_q.param_loaded;

endmodule : pwd_decoder_top

// *** tb/pwd_asserts.sv ***
// Concurrent checks on the parameter word decoder top ports
module pwd_asserts #(
	parameter logic [7:0] ROM_WORD_ADDR   = 8'h08,
	parameter logic [7:0] PARAM_WORD_ADDR = 8'h07
) (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        ee_word_valid,
	input wire logic [7:0]  ee_word_addr,
	input wire logic [15:0] ee_word_data,
	input wire logic        pme_oe,
	input wire logic [31:0] memory_window_base,
	input wire logic [7:0]  minimum_grant_register,
	input wire logic [7:0]  maximum_latency_register,
	input wire logic        memory_window_off,
	input wire logic        bios_rom_installed,
	input wire logic [1:0]  bios_rom_capacity,
	input wire logic        bios_rom_capacity_reserved,
	input wire logic        param_loaded
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Properties
	// ********************
	logic pl;
	logic rl;
	assign pl = ee_word_valid && ee_word_addr == PARAM_WORD_ADDR;
	assign rl = ee_word_valid && ee_word_addr == ROM_WORD_ADDR;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_min_grant;
		pl |=> minimum_grant_register == {3'h0, $past(ee_word_data[9:6]), 1'h0};
	endproperty
	a_min_grant: assert property (p_min_grant) else $error("min grant wrong");
	property p_max_lat;
		pl |=> maximum_latency_register == {2'h0, $past(ee_word_data[15:10])};
	endproperty
	a_max_lat: assert property (p_max_lat) else $error("max latency wrong");
	property p_map_low;
		pl |=> memory_window_base[1] == $past(ee_word_data[1]) && memory_window_off == $past(ee_word_data[2]);
	endproperty
	a_map_low: assert property (p_map_low) else $error("window bits wrong");
	property p_hide;
		memory_window_off |-> memory_window_base[31:7] == 25'h0;
	endproperty
	a_hide: assert property (p_hide) else $error("hidden base not zero");
	property p_rom;
		rl |=> bios_rom_installed == $past(ee_word_data[11]) && bios_rom_capacity == $past(ee_word_data[13:12]);
	endproperty
	a_rom: assert property (p_rom) else $error("rom fields wrong");
	property p_rsv;
		bios_rom_capacity_reserved == (bios_rom_installed && bios_rom_capacity[1]);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
	property p_loaded;
		pl |=> param_loaded;
	endproperty
	a_loaded: assert property (p_loaded) else $error("load flag missing");
	property p_default;
		$rose(rst_b) |-> minimum_grant_register == 8'h0A && maximum_latency_register == 8'h05 && !param_loaded;
	endproperty
	a_default: assert property (p_default) else $error("default word wrong");
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	cover property (pl);
	cover property (rl && ee_word_data[11]);
	cover property ($rose(pme_oe));
endmodule : pwd_asserts

// *** tb/pwd_ee_model.sv ***
// Model of the EEPROM loader and the pulled-up PME line
module pwd_ee_model (
	input  wire logic        ref_clk,
	input  wire logic        pme_oe,
	output logic             ee_word_valid,
	output logic      [7:0]  ee_word_addr,
	output logic      [15:0] ee_word_data,
	output logic             pme_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Loader
	// ********************
	initial begin
		ee_word_valid = 1'h0;
		ee_word_addr  = 8'h00;
		ee_word_data  = 16'h0000;
	end
	// Pull-up wins unless the device pulls low
	assign pme_line = !pme_oe;
	// Data inverted after the strobe so stale words never look valid
	task automatic load(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		ee_word_valid <= 1'h1;
		ee_word_addr  <= a;
		ee_word_data  <= d;
		@(posedge ref_clk);
		ee_word_valid <= 1'h0;
		ee_word_data  <= ~d;
	endtask : load
endmodule : pwd_ee_model

// *** tb/tb_top.sv ***
// Self-checking bench for the parameter word decoder
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Harness
	// ********************
	localparam int unsigned PC = 20;
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, ee_word_valid, wake_event_pin, pme_i;
	logic pme_o, pme_oe, memory_window_off, bios_rom_installed, bios_rom_capacity_reserved, param_loaded;
	logic [7:0]  avs_address, ee_word_addr, minimum_grant_register, maximum_latency_register;
	logic [31:0] avs_writedata, avs_readdata, memory_window_base;
	logic [15:0] ee_word_data;
	logic [1:0]  bios_rom_capacity;
	int          miscompares, checks_done, n;
	pwd_decoder_top #(.PME_PULSE_CYCLES(PC), .ROM_WORD_ADDR(8'h08), .PARAM_WORD_ADDR(8'h07)) i_dut (
		.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata,
		.avs_readdata, .avs_waitrequest, .ee_word_valid, .ee_word_addr, .ee_word_data, .wake_event_pin,
		.pme_i, .pme_o, .pme_oe, .memory_window_base, .minimum_grant_register, .maximum_latency_register,
		.memory_window_off, .bios_rom_installed, .bios_rom_capacity, .bios_rom_capacity_reserved, .param_loaded);
	pwd_ee_model i_ee (.ref_clk, .pme_oe, .ee_word_valid, .ee_word_addr, .ee_word_data, .pme_line(pme_i));
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : chk
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge ref_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			t++;
		end while (avs_waitrequest !== 1'h0 && t < 40);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (t >= 40) miscompares++;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk($sformatf("read %h", a), e, q);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask : wr
	task automatic ld_param(input logic [15:0] w);
		i_ee.load(8'h07, w);
		@(negedge ref_clk);
		chk("min grant", 32'({3'h0, w[9:6], 1'h0}), 32'(minimum_grant_register));
		chk("max latency", 32'({2'h0, w[15:10]}), 32'(maximum_latency_register));
		chk("window off", 32'(w[2]), 32'(memory_window_off));
		chk("map low", 32'(w[1]), 32'(memory_window_base[1]));
		chk("loaded", 32'h1, 32'(param_loaded));
		rd(8'h04, 32'(w));
		rd(8'h0C, {18'h0, w[15:10], 3'h0, w[9:6], 1'h0});
	endtask : ld_param
	task automatic ld_rom(input logic [15:0] w);
		i_ee.load(8'h08, w);
		@(negedge ref_clk);
		chk("installed", 32'(w[11]), 32'(bios_rom_installed));
		chk("capacity", 32'(w[13:12]), 32'(bios_rom_capacity));
		chk("rom size", 32'(w[11] ? w[13:12] : 2'h0), 32'(bios_rom_installed ? bios_rom_capacity : 2'h0));
		chk("reserved", 32'(w[11] & w[13]), 32'(bios_rom_capacity_reserved));
		rd(8'h00, 32'(w));
	endtask : ld_rom
	// Level mode never ends by itself, so the count stops at 4*PC
	task automatic wake(output int c);
		int t;
		t = 0;
		c = 0;
		@(posedge ref_clk);
		wake_event_pin <= 1'h1;
		while (pme_oe !== 1'h1 && t < 20) begin
			@(posedge ref_clk);
			t++;
		end
		wake_event_pin <= 1'h0;
		while (pme_oe === 1'h1 && c < 4 * PC) begin
			@(posedge ref_clk);
			c++;
		end
	endtask : wake
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end
	// ********************
	// Tests
	// ********************
	initial begin
		static logic [15:0] pw [4] = '{16'h0038, 16'hFFC7, 16'hA5A5, 16'h5A5A};
		rst_b = 1'h0;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		wake_event_pin = 1'h0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(negedge ref_clk);
		chk("min grant", 32'h0A, 32'(minimum_grant_register));
		chk("max latency", 32'h05, 32'(maximum_latency_register));
		chk("loaded", 32'h0, 32'(param_loaded));
		rd(8'h04, 32'h1540);
		rd(8'h20, 32'h0);
		foreach (pw[i]) ld_param(pw[i]);
		wr(8'h04, 32'h1234);
		rd(8'h04, 32'h5A5A);
		ld_param(16'h0002);
		wr(8'h08, 32'hFFFFFFFF);
		rd(8'h08, 32'hFFFFFF82);
		ld_param(16'h0004);
		rd(8'h08, 32'h0);
		chk("base", 32'h0, memory_window_base);
		for (int i = 0; i < 8; i++) ld_rom({2'h0, 3'(i), 11'h0});
		i_ee.load(8'h09, 16'h0000);
		rd(8'h00, 32'h3800);
		wr(8'h14, 32'h1);
		ld_param(16'h0001);
		wake(n);
		chk("pulse length", 32'(PC), 32'(n));
		ld_param(16'h0000);
		wake(n);
		chk("level length", 32'(4 * PC), 32'(n));
		chk("pme drive", 32'h0, 32'(pme_o));
		wr(8'h10, 32'h4);
		// Enable follows the cleared level one cycle later
		repeat (2) @(negedge ref_clk);
		chk("pme cleared", 32'h0, 32'(pme_oe));
		wr(8'h14, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h10, 32'h33);
		wake(n);
		chk("masked wake", 32'h0, 32'(n));
		@(posedge ref_clk);
		rst_b <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'h1;
		@(negedge ref_clk);
		chk("min grant", 32'h0A, 32'(minimum_grant_register));
		chk("loaded", 32'h0, 32'(param_loaded));
		rd(8'h04, 32'h1540);
		wrap_up();
	end
endmodule : tb_top

bind pwd_decoder_top pwd_asserts #(.ROM_WORD_ADDR(ROM_WORD_ADDR), .PARAM_WORD_ADDR(PARAM_WORD_ADDR)) i_chk (
	.ref_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .ee_word_valid, .ee_word_addr, .ee_word_data,
	.pme_oe, .memory_window_base, .minimum_grant_register, .maximum_latency_register, .memory_window_off,
	.bios_rom_installed, .bios_rom_capacity, .bios_rom_capacity_reserved, .param_loaded);
